// File: hdl/five_channel_dma_controller.sv
// five-channel dma engine with an ahb-lite register slave and a byte memory master
// assumes a shared byte memory with combinational read data and hclk-synchronous trigger pulses
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "dma_ctrl_regs.svh"
module five_channel_dma_controller #(
  parameter int NCH = 5,
  parameter int NTRIG = 31
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory master shared with the cpu
  input wire logic cpu_req,
  input wire logic [7:0] mem_rdata,
  output dma_pkg::mem_bus_t mem_out,
  output logic cpu_hold,
  // trigger events and completion interrupt
  input wire logic [NTRIG-1:0] trig_in,
  output logic irq
);
  dma_pkg::seq_state_t state_reg;
  dma_pkg::phase_t phase_reg;
  dma_pkg::mem_bus_t mem_reg;
  logic [2:0] ch_reg, rr_reg, bidx_reg, pick, chm1;
  logic [15:0] buf_reg, desc_base, cur_addr;
  logic lost_reg, hold_reg, irq_reg, hreadyout_reg, hresp_reg, wr_pend_reg;
  logic [31:0] hrdata_reg, rd_val;
  logic [7:0] wa_reg, wbyte;
  logic [NCH-1:0] channel_arm_reg, loaded_reg, pend_reg, soft_request_reg, completion_flag_reg;
  logic [NCH-1:0] arm_next, loaded_next, pend_next, sreq_next, flag_next;
  logic [NCH-1:0] want, hit_vec, irqen, done_vec, wbits;
  logic [NCH-1:0][1:0] lvl;
  logic [7:0] descriptor_ptr_low_reg [2];
  logic [7:0] descriptor_ptr_high_reg [2];
  logic [7:0] desc_mem [NCH][8];
  logic [15:0] src_ptr [NCH];
  logic [15:0] dst_ptr [NCH];
  logic [12:0] done_cnt [NCH];
  logic [12:0] lim_reg [NCH];
  logic [NCH-1:0] first_reg;
  logic [7:0] b4, b5, b6, b7;
  logic [12:0] len_cfg, len_data, lim_now, cnt_n;
  logic [13:0] calc, cap;
  logic [1:0] maxl, tmode;
  logic wsize, m8, last_b, in_data, unit_end, fetch_end, complete, win, any_want, found;
  logic take, map, wr_en, arm_wr, abort_wr, kill;
  int idx;

  // outputs straight from flops
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign mem_out = mem_reg;
  assign cpu_hold = hold_reg;
  assign irq = irq_reg;

  // fields of the channel in service
  assign b4 = desc_mem[ch_reg][4];
  assign b5 = desc_mem[ch_reg][5];
  assign b6 = desc_mem[ch_reg][6];
  assign b7 = desc_mem[ch_reg][7];
  assign len_cfg = {b4[`D4_LENH], b5};
  assign wsize = b6[`D6_WORD];
  assign m8 = b7[`D7_M8];
  assign tmode = b6[`D6_TMODE];

  // register write decode, applied at the end of the data phase
  assign wbits = hwdata[NCH-1:0];
  assign wr_en = wr_pend_reg;
  assign arm_wr = wr_en && wa_reg == `ARM_OFF;
  assign abort_wr = arm_wr && hwdata[`ARM_ABORT_BIT];
  assign kill = abort_wr && wbits[ch_reg];

  // sequencer events
  assign last_b = !wsize || bidx_reg[0];
  assign in_data = state_reg == dma_pkg::S_DATA;
  assign unit_end = in_data && phase_reg == dma_pkg::PH_WRITE && last_b && !kill;
  assign fetch_end = in_data && phase_reg == dma_pkg::PH_FETCH && bidx_reg == `DESC_LAST && !kill;
  assign cnt_n = done_cnt[ch_reg] + 13'h0001;
  assign complete = cnt_n >= lim_now;

  // per-channel trigger select, request and arbitration level
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [4:0] tsel;
    logic [1:0] pr;
    assign tsel = desc_mem[i][6][`D6_TRIG];
    assign pr = desc_mem[i][7][`D7_PRIO];
    // trigger 1 chains on the completion of the channel below; channel 0 chains on channel 4
    assign hit_vec[i] = (tsel == `TRIG_NONE) ? 1'b0 :
                        (tsel == `TRIG_PREV) ? done_vec[(i + NCH - 1) % NCH] :
                        (int'(tsel) < NTRIG) ? trig_in[tsel] : 1'b0;
    assign want[i] = channel_arm_reg[i] && (!loaded_reg[i] || pend_reg[i]);
    // descriptor fetches ride at high level so a fresh arm is not starved
    assign lvl[i] = !loaded_reg[i] ? `PRIO_HIGH : (pr[1] ? `PRIO_HIGH : pr);
    assign irqen[i] = desc_mem[i][7][`D7_IRQEN];
  end

  // highest level wins, round robin from the last served among equals
  always_comb begin
    maxl = `PRIO_LOW;
    pick = rr_reg;
    found = 1'b0;
    idx = 0;
    any_want = |want;
    for (int i = 0; i < NCH; i++) begin
      if (want[i] && lvl[i] > maxl) maxl = lvl[i];
    end
    for (int k = 1; k <= NCH; k++) begin
      idx = (int'(rr_reg) + k) % NCH;
      if (!found && want[idx] && lvl[idx] == maxl) begin
        pick = 3'(idx);
        found = 1'b1;
      end
    end
  end

  // slot against the cpu: high takes it, normal every second try, low waits
  assign win = !cpu_req || lvl[ch_reg] == `PRIO_HIGH || (lvl[ch_reg] == `PRIO_NORMAL && lost_reg);

  // descriptor location: channel 0 alone, channels 1..4 packed after one pointer
  assign chm1 = ch_reg - 3'h1;
  assign desc_base = (ch_reg == 3'h0) ? {descriptor_ptr_high_reg[0], descriptor_ptr_low_reg[0]} :
                     {descriptor_ptr_high_reg[1], descriptor_ptr_low_reg[1]} + {10'h000, chm1, 3'h0};
  always_comb begin
    case (phase_reg)
      dma_pkg::PH_FETCH: cur_addr = desc_base + {13'h0000, bidx_reg};
      dma_pkg::PH_READ: cur_addr = src_ptr[ch_reg] + {15'h0000, bidx_reg[0]};
      default: cur_addr = dst_ptr[ch_reg] + {15'h0000, bidx_reg[0]};
    endcase
  end
  // low byte of a word sits at the lower address
  assign wbyte = bidx_reg[0] ? buf_reg[15:8] : buf_reg[7:0];

  // unit count: fixed length or one taken from the first unit, capped
  always_comb begin
    if (wsize) len_data = buf_reg[12:0];
    else if (m8) len_data = {5'h00, buf_reg[7:0]};
    else len_data = {6'h00, buf_reg[6:0]};
    case (b4[`D4_VAR_LENGTH_MODE])
      `VAR_LENGTH_MODE_PLUS1: calc = {1'b0, len_data} + 14'h0001;
      `VAR_LENGTH_MODE_EXACT: calc = {1'b0, len_data};
      `VAR_LENGTH_MODE_PLUS2: calc = {1'b0, len_data} + 14'h0002;
      `VAR_LENGTH_MODE_PLUS3: calc = {1'b0, len_data} + 14'h0003;
      default: calc = {1'b0, len_cfg};
    endcase
    cap = (calc > {1'b0, len_cfg}) ? {1'b0, len_cfg} : calc;
    if (b4[`D4_VAR_LENGTH_MODE] == `VAR_LENGTH_MODE_OFF) lim_now = len_cfg;
    else if (first_reg[ch_reg]) lim_now = cap[12:0];
    else lim_now = lim_reg[ch_reg];
  end

  function automatic logic [15:0] step_of(input logic [1:0] inc, input logic word);
    logic [15:0] u;
    u = word ? 16'h0002 : 16'h0001;
    case (inc)
      `INC_FIXED: step_of = 16'h0000;
      `INC_ONE: step_of = u;
      `INC_TWO: step_of = {u[14:0], 1'b0};
      default: step_of = 16'h0000 - u;
    endcase
  endfunction

  // byte sequencer: pick a channel, win a slot, move one byte per access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= dma_pkg::S_IDLE;
      phase_reg <= dma_pkg::PH_FETCH;
      ch_reg <= 3'h0;
      rr_reg <= 3'h4;
      bidx_reg <= 3'h0;
      buf_reg <= 16'h0000;
      lost_reg <= 1'b0;
      mem_reg <= '0;
      hold_reg <= 1'b0;
    end else begin
      mem_reg.req <= 1'b0;
      hold_reg <= 1'b0;
      case (state_reg)
        dma_pkg::S_IDLE: begin
          if (any_want) begin
            ch_reg <= pick;
            rr_reg <= pick;
            bidx_reg <= 3'h0;
            phase_reg <= loaded_reg[pick] ? dma_pkg::PH_READ : dma_pkg::PH_FETCH;
            state_reg <= dma_pkg::S_ISSUE;
          end
        end
        dma_pkg::S_ISSUE: begin
          if (!channel_arm_reg[ch_reg] || kill) begin
            state_reg <= dma_pkg::S_IDLE;
          end else if (win) begin
            mem_reg.req <= 1'b1;
            mem_reg.we <= phase_reg == dma_pkg::PH_WRITE;
            mem_reg.addr <= cur_addr;
            mem_reg.wdata <= wbyte;
            hold_reg <= cpu_req;
            lost_reg <= 1'b0;
            state_reg <= dma_pkg::S_DATA;
          end else if (lvl[ch_reg] == `PRIO_NORMAL) begin
            lost_reg <= 1'b1;
          end
        end
        dma_pkg::S_DATA: begin
          case (phase_reg)
            dma_pkg::PH_FETCH: begin
              if (kill || bidx_reg == `DESC_LAST) begin
                state_reg <= dma_pkg::S_IDLE;
              end else begin
                bidx_reg <= bidx_reg + 3'h1;
                state_reg <= dma_pkg::S_ISSUE;
              end
            end
            dma_pkg::PH_READ: begin
              if (bidx_reg[0]) buf_reg[15:8] <= mem_rdata;
              else buf_reg[7:0] <= mem_rdata;
              if (wsize && !bidx_reg[0]) begin
                bidx_reg <= 3'h1;
              end else begin
                bidx_reg <= 3'h0;
                phase_reg <= dma_pkg::PH_WRITE;
              end
              state_reg <= kill ? dma_pkg::S_IDLE : dma_pkg::S_ISSUE;
            end
            default: begin
              if (!last_b && !kill) begin
                bidx_reg <= 3'h1;
                state_reg <= dma_pkg::S_ISSUE;
              end else begin
                state_reg <= dma_pkg::S_IDLE;
              end
            end
          endcase
        end
        default: state_reg <= dma_pkg::S_IDLE;
      endcase
    end
  end

  // descriptor store, working pointers and counts per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        for (int j = 0; j < 8; j++) desc_mem[i][j] <= `PTR_RST;
        src_ptr[i] <= 16'h0000;
        dst_ptr[i] <= 16'h0000;
        done_cnt[i] <= 13'h0000;
        lim_reg[i] <= 13'h0000;
      end
      first_reg <= '0;
    end else begin
      if (in_data && phase_reg == dma_pkg::PH_FETCH && !kill) desc_mem[ch_reg][bidx_reg] <= mem_rdata;
      if (fetch_end) begin
        src_ptr[ch_reg] <= {desc_mem[ch_reg][0], desc_mem[ch_reg][1]};
        dst_ptr[ch_reg] <= {desc_mem[ch_reg][2], desc_mem[ch_reg][3]};
        done_cnt[ch_reg] <= 13'h0000;
        first_reg[ch_reg] <= 1'b1;
      end
      if (unit_end) begin
        if (complete) begin
          // repeated modes start over from the configured addresses
          if (tmode[`TM_REPEAT_BIT]) begin
            src_ptr[ch_reg] <= {desc_mem[ch_reg][0], desc_mem[ch_reg][1]};
            dst_ptr[ch_reg] <= {desc_mem[ch_reg][2], desc_mem[ch_reg][3]};
          end
          done_cnt[ch_reg] <= 13'h0000;
          first_reg[ch_reg] <= 1'b1;
        end else begin
          src_ptr[ch_reg] <= src_ptr[ch_reg] + step_of(b7[`D7_SINC], wsize);
          dst_ptr[ch_reg] <= dst_ptr[ch_reg] + step_of(b7[`D7_DINC], wsize);
          done_cnt[ch_reg] <= cnt_n;
          lim_reg[ch_reg] <= lim_now;
          first_reg[ch_reg] <= 1'b0;
        end
      end
    end
  end

  // next state of arm, fetch, pending, request and flag bits; every set wins over its clear except an arm write on fetch and a disarm on fetch and pending
  always_comb begin
    done_vec = '0;
    if (unit_end && complete) done_vec[ch_reg] = 1'b1;
    arm_next = channel_arm_reg;
    if (unit_end && complete && !tmode[`TM_REPEAT_BIT]) arm_next[ch_reg] = 1'b0;
    if (abort_wr) arm_next = arm_next & ~wbits;
    else if (arm_wr) arm_next = arm_next | wbits;
    loaded_next = loaded_reg;
    if (fetch_end) loaded_next[ch_reg] = 1'b1;
    if (arm_wr && !abort_wr) loaded_next = loaded_next & ~wbits;
    loaded_next = loaded_next & arm_next;
    pend_next = pend_reg;
    if (unit_end && (!tmode[`TM_BLOCK_BIT] || complete)) pend_next[ch_reg] = 1'b0;
    pend_next = (pend_next | ((hit_vec | soft_request_reg) & channel_arm_reg & loaded_reg)) & arm_next;
    sreq_next = soft_request_reg & ~(channel_arm_reg & loaded_reg);
    if (wr_en && wa_reg == `SREQ_OFF) sreq_next = sreq_next | wbits;
    flag_next = completion_flag_reg;
    if (wr_en && wa_reg == `FLAG_OFF) flag_next = flag_next & ~wbits;
    flag_next = flag_next | done_vec;
  end

  // control bits; reset leaves everything idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_arm_reg <= `CTRL_RST;
      loaded_reg <= `CTRL_RST;
      pend_reg <= `CTRL_RST;
      soft_request_reg <= `CTRL_RST;
      completion_flag_reg <= `CTRL_RST;
      irq_reg <= 1'b0;
    end else begin
      channel_arm_reg <= arm_next;
      loaded_reg <= loaded_next;
      pend_reg <= pend_next;
      soft_request_reg <= sreq_next;
      completion_flag_reg <= flag_next;
      irq_reg <= |(flag_next & irqen);
    end
  end

  // ahb-lite slave: zero wait states, read data latched in the address phase
  assign take = hsel && htrans[1] && hready;
  assign map = haddr[31:8] == 24'h000000;
  always_comb begin
    case (haddr[7:0])
      `ARM_OFF: rd_val = 32'(channel_arm_reg);
      `SREQ_OFF: rd_val = 32'(soft_request_reg);
      `FLAG_OFF: rd_val = 32'(completion_flag_reg);
      `P0L_OFF: rd_val = {24'h000000, descriptor_ptr_low_reg[0]};
      `P0H_OFF: rd_val = {24'h000000, descriptor_ptr_high_reg[0]};
      `P1L_OFF: rd_val = {24'h000000, descriptor_ptr_low_reg[1]};
      `P1H_OFF: rd_val = {24'h000000, descriptor_ptr_high_reg[1]};
      `STAT_OFF: rd_val = 32'({ch_reg, state_reg != dma_pkg::S_IDLE, 3'h0, loaded_reg});
      default: rd_val = 32'h00000000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite && map;
      wa_reg <= haddr[7:0];
      hrdata_reg <= (take && !hwrite && map) ? rd_val : 32'h00000000;
    end
  end

  // descriptor pointer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        descriptor_ptr_low_reg[i] <= `PTR_RST;
        descriptor_ptr_high_reg[i] <= `PTR_RST;
      end
    end else if (wr_en) begin
      if (wa_reg == `P0L_OFF) descriptor_ptr_low_reg[0] <= hwdata[7:0];
      if (wa_reg == `P0H_OFF) descriptor_ptr_high_reg[0] <= hwdata[7:0];
      if (wa_reg == `P1L_OFF) descriptor_ptr_low_reg[1] <= hwdata[7:0];
      if (wa_reg == `P1H_OFF) descriptor_ptr_high_reg[1] <= hwdata[7:0];
    end
  end

  // checks on the behaviour above
  arm_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arm_wr && !abort_wr |=> (channel_arm_reg & $past(wbits)) == $past(wbits))
    else $error("arm write did not arm");
  abort_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    abort_wr |=> (channel_arm_reg & $past(wbits)) == '0)
    else $error("abort left a channel armed");
  armed_move_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(mem_reg.req) && phase_reg != dma_pkg::PH_FETCH |-> $past(channel_arm_reg[ch_reg]))
    else $error("transfer from unarmed channel");
  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unit_end && complete |=> completion_flag_reg[$past(ch_reg)])
    else $error("completion flag not set");
  low_yield_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == dma_pkg::S_ISSUE && cpu_req && lvl[ch_reg] == `PRIO_LOW |=> !mem_reg.req)
    else $error("low priority took cpu slot");
  high_win_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == dma_pkg::S_ISSUE && lvl[ch_reg] == `PRIO_HIGH && channel_arm_reg[ch_reg] && !kill
    |=> mem_reg.req && mem_reg.addr == $past(cur_addr))
    else $error("high priority lost slot");
  normal_win_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == dma_pkg::S_ISSUE && cpu_req && lvl[ch_reg] == `PRIO_NORMAL && channel_arm_reg[ch_reg]
    |-> ##[1:2] (mem_reg.req || state_reg == dma_pkg::S_IDLE))
    else $error("normal priority starved");
  single_disarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unit_end && complete && !b6[6] && !arm_wr |=> !channel_arm_reg[$past(ch_reg)])
    else $error("non-repeat channel stayed armed");
  len_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unit_end && b4[`D4_VAR_LENGTH_MODE] != `VAR_LENGTH_MODE_OFF |-> lim_now <= len_cfg)
    else $error("length above configured ceiling");
endmodule

// File: common/dma_ctrl_regs.svh
// register offsets, descriptor field positions, codes and reset values of the dma block
// assumes inclusion by bare name from design files
`ifndef DMA_CTRL_REGS_SVH
`define DMA_CTRL_REGS_SVH
// byte offsets on the register bus
`define ARM_OFF 8'h00
`define SREQ_OFF 8'h04
`define FLAG_OFF 8'h08
`define P0L_OFF 8'h0C
`define P0H_OFF 8'h10
`define P1L_OFF 8'h14
`define P1H_OFF 8'h18
`define STAT_OFF 8'h1C
`define ARM_ABORT_BIT 7
// descriptor layout, eight bytes per channel
`define DESC_LAST 3'h7
`define D4_VAR_LENGTH_MODE 7:5
`define D4_LENH 4:0
`define D6_WORD 7
`define D6_TMODE 6:5
`define D6_TRIG 4:0
`define D7_SINC 7:6
`define D7_DINC 5:4
`define D7_IRQEN 3
`define D7_M8 2
`define D7_PRIO 1:0
// transfer mode bits, length modes, trigger codes, priorities, steps
`define TM_BLOCK_BIT 0
`define TM_REPEAT_BIT 1
`define VAR_LENGTH_MODE_OFF 3'h0
`define VAR_LENGTH_MODE_PLUS1 3'h1
`define VAR_LENGTH_MODE_EXACT 3'h2
`define VAR_LENGTH_MODE_PLUS2 3'h3
`define VAR_LENGTH_MODE_PLUS3 3'h4
`define TRIG_NONE 5'h00
`define TRIG_PREV 5'h01
`define PRIO_LOW 2'h0
`define PRIO_NORMAL 2'h1
`define PRIO_HIGH 2'h2
`define INC_FIXED 2'h0
`define INC_ONE 2'h1
`define INC_TWO 2'h2
// reset values
`define CTRL_RST 5'h00
`define PTR_RST 8'h00
`endif

// File: common/dma_pkg.sv
// types shared by the dma block and its bench
// assumes nothing of its surroundings
package dma_pkg;
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_ISSUE = 3'b010, S_DATA = 3'b100} seq_state_t;
  typedef enum logic [2:0] {PH_FETCH = 3'b001, PH_READ = 3'b010, PH_WRITE = 3'b100} phase_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_bus_t;
endpackage

// File: verif/mem_model.sv
// byte memory on the dma master port; cpu traffic itself comes from the bench
// assumes registered mem_out and wants read data to follow the address at once
`timescale 1ns/1ps
module mem_model (
  // clock
  input wire logic hclk,
  // dma master port
  input wire dma_pkg::mem_bus_t mem_out,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] last;
  // idle read data flips every cycle so a late sample never looks valid
  assign mem_rdata = mem_out.req ? m[mem_out.addr] : ~last;
  // every address is writable, so no destination byte is lost
  always @(posedge hclk) begin
    last <= mem_rdata;
    if (mem_out.req && mem_out.we) begin
      m[mem_out.addr] <= mem_out.wdata;
    end
  end
  initial begin
    last = 8'h00;
    foreach (m[i]) m[i] = 8'h00;
  end
endmodule

// File: verif/five_channel_dma_controller_tb_top.sv
// self-checking bench: ahb-lite master, random cpu contention, expected bytes kept in a queue
// assumes the memory model above and zero-wait register answers
`timescale 1ns/1ps
module five_channel_dma_controller_tb_top;
  logic hclk, hresetn, hsel, hwrite, cpu_req, irq, hreadyout, hresp, cpu_hold;
  logic [31:0] haddr, hwdata, hrdata, rv, seed, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] mem_rdata;
  logic [30:0] trig_in;
  dma_pkg::mem_bus_t mem_out;
  int n_fail, compares, wn;
  logic [7:0] srcq [$];
  // length mode, first byte, cap, full-width length, expected units; caps sit above the run except in the fifth row, where cap 3 trims 9
  logic [7:0] vt [6][5] = '{'{1, 2, 10, 1, 3}, '{2, 4, 10, 1, 4}, '{3, 2, 10, 1, 4}, '{4, 2, 10, 1, 5},
    '{2, 9, 3, 1, 3}, '{2, 8'h83, 10, 0, 3}};
  five_channel_dma_controller DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_req(cpu_req), .mem_rdata(mem_rdata), .mem_out(mem_out), .cpu_hold(cpu_hold),
    .trig_in(trig_in), .irq(irq));
  mem_model mem (.hclk(hclk), .mem_out(mem_out), .mem_rdata(mem_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // cpu wants the memory about a quarter of the cycles
  always @(posedge hclk) begin
    seed <= lfsr(seed);
    cpu_req <= seed[0] & seed[3];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // one single transfer; hready and read data are sampled settled, before the edge that takes them
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    logic r;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      rv = hrdata;
      @(posedge hclk);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
    ahb(1'b0, a, 32'h0);
    chk(rv, exp, msg);
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask
  // the cpu is told to wait only in a cycle in which the dma really holds the memory
  always @(negedge hclk) begin
    if (hresetn && cpu_hold) chk({31'h0, mem_out.req}, 32'h1, "hold without access");
  end
  // bounded wait for one register bit
  task automatic poll(input logic [31:0] a, input int b, input logic v);
    int n;
    n = 0;
    rv = {32{~v}};
    while (rv[b] !== v && n < 3000) begin
      ahb(1'b0, a, 32'h0);
      n++;
    end
    chk({31'h0, rv[b]}, {31'h0, v}, "poll timeout");
  endtask
  task automatic desc(input logic [15:0] base, input logic [15:0] s, input logic [15:0] d,
    input logic [7:0] b4, input logic [7:0] b5, input logic [7:0] b6, input logic [7:0] b7);
    logic [7:0] dd [8];
    dd = '{s[15:8], s[7:0], d[15:8], d[7:0], b4, b5, b6, b7};
    for (int i = 0; i < 8; i++) begin
      mem.m[base + i] = dd[i];
    end
  endtask
  // channel 0 run on a soft request; dec makes the destination walk down
  task automatic blk(input logic [7:0] b4, input logic [7:0] b5, input logic [7:0] b6, input logic [7:0] b7,
    input logic [7:0] first, input logic usefirst, input int n, input logic dec);
    srcq.delete();
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      srcq.push_back(rnd[7:0]);
      mem.m[16'h1000 + i] = rnd[7:0];
      mem.m[16'h2000 + i] = 8'hA5;
    end
    if (usefirst) begin
      srcq[0] = first;
      mem.m[16'h1000] = first;
    end
    desc(16'h0100, 16'h1000, dec ? 16'h2003 : 16'h2000, b4, b5, b6, b7);
    ahb(1'b1, 32'h00, 32'h1);
    poll(32'h1C, 0, 1'b1);
    ahb(1'b1, 32'h04, 32'h1);
    poll(32'h08, 0, 1'b1);
    for (int i = 0; i < n; i++) begin
      chk(32'(mem.m[dec ? 16'h2003 - i : 16'h2000 + i]), 32'(srcq[i]), "copied byte");
    end
    if (!dec) begin
      chk(32'(mem.m[16'h2000 + n]), 32'hA5, "byte past count");
    end
    chk({31'h0, irq}, {31'h0, b7[3]}, "irq level");
    rd(32'h00, 32'h0, "block not disarmed");
    ahb(1'b1, 32'h08, 32'h1);
    rd(32'h08, 32'h0, "flag not cleared");
    chk({31'h0, irq}, 32'h0, "irq after clear");
  endtask
  task automatic conclude();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // the whole sequence needs well under a tenth of this span
  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    conclude();
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, cpu_req, trig_in, n_fail, compares} = '0;
    hsize = 3'h2;
    seed = 32'hd2f3c5ed;
    rnd = 32'hd2f3c5ed;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h00, 32'h0, "arm after reset");
    rd(32'h04, 32'h0, "request after reset");
    rd(32'h08, 32'h0, "flags after reset");
    rd(32'h100, 32'h0, "unmapped read");
    // descriptor pointers: channel 0 at 0x0100, channels 1..4 from 0x0200
    ahb(1'b1, 32'h10, 32'h1);
    ahb(1'b1, 32'h18, 32'h2);
    ahb(1'b1, 32'h04, 32'h4);
    repeat (60) @(posedge hclk);
    rd(32'h08, 32'h0, "unarmed channel ran");
    blk(8'h00, 8'h04, 8'h20, 8'h79, 8'h00, 1'b0, 4, 1'b1);
    for (int i = 0; i < 6; i++) begin
      blk({vt[i][0][2:0], 5'h0}, vt[i][2], 8'h20, {5'b01010, vt[i][3][0], 2'h2}, vt[i][1], 1'b1, vt[i][4], 1'b0);
    end
    // channel 1: word units, single mode on trigger 5, destination steps two words
    srcq.delete();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      srcq.push_back(rnd[7:0]);
      mem.m[16'h1100 + i] = rnd[7:0];
    end
    desc(16'h0200, 16'h1100, 16'h2100, 8'h00, 8'h02, 8'h85, 8'h62);
    ahb(1'b1, 32'h00, 32'h2);
    poll(32'h1C, 1, 1'b1);
    for (int t = 0; t < 2; t++) begin
      @(posedge hclk);
      trig_in[5] <= 1'b1;
      @(posedge hclk);
      trig_in[5] <= 1'b0;
      wn = 0;
      while (mem.m[16'h2101 + 4 * t] !== srcq[2 * t + 1] && wn < 500) begin
        @(posedge hclk);
        wn++;
      end
      repeat (4) @(posedge hclk);
      rd(32'h08, {30'h0, t[0], 1'b0}, "single mode flag");
      rd(32'h00, {30'h0, ~t[0], 1'b0}, "single mode arm");
    end
    for (int i = 0; i < 4; i++) begin
      chk(32'(mem.m[16'h2100 + 4 * (i / 2) + i % 2]), 32'(srcq[i]), "word byte");
    end
    chk({31'h0, irq}, 32'h0, "masked irq");
    ahb(1'b1, 32'h08, 32'h2);
    // abort only the channels written as one
    ahb(1'b1, 32'h00, 32'h18);
    rd(32'h00, 32'h18, "arm two");
    ahb(1'b1, 32'h00, 32'h88);
    rd(32'h00, 32'h10, "abort one");
    ahb(1'b1, 32'h00, 32'h90);
    rd(32'h00, 32'h0, "abort other");
    conclude();
  end
endmodule
